// >>> shared/cvsm_defs.vh
// constants for the vertical standby and field-sequence configuration block
`ifndef CVSM_DEFS_VH
`define CVSM_DEFS_VH

// apb address: word index is paddr[13:2]
`define CVSM_ADDR_W 14
`define CVSM_IDX_W 12
`define CVSM_IDX_LSB 2
`define CVSM_IDX_MSB 13

// register indices, byte address is four times the index
`define CVSM_IDX_POL 12'h0F3
`define CVSM_IDX_MODE_ACT_LO 12'h0F4
`define CVSM_IDX_MODE_ACT_HI 12'h0F5
`define CVSM_IDX_FIELD_STAT 12'h0F6
`define CVSM_IDX_MODE_PEND_HI 12'h0F7

// mode register select: index bits 11:10 equal 10
`define CVSM_MODE_SEL_MSB 11
`define CVSM_MODE_SEL_LSB 10
`define CVSM_MODE_SEL_CODE 2'h2
`define CVSM_MODE_ADDR_DATA_W 10
`define CVSM_MODE_LOW_W 28

// toggle position table: 32 words of two 13-bit positions
`define CVSM_TOG_DEPTH 32
`define CVSM_TOG_AW 5
`define CVSM_TOG_POS_W 13
`define CVSM_TOG_WORD_W 26
`define CVSM_TOG_HI_IDX 7'h00

// polarity register layout
`define CVSM_POL_W 22
`define CVSM_POL_VT_LSB 0
`define CVSM_POL_VT_MSB 12
`define CVSM_POL_SG_LSB 13
`define CVSM_POL_SG_MSB 20
`define CVSM_POL_SUB_BIT 21
`define CVSM_POL_RESET 22'h000000

// mode register layout
`define CVSM_MODE_W 38
`define CVSM_MODE_RESET 38'h0000000000
`define CVSM_MODE_CNT_MSB 37
`define CVSM_MODE_CNT_LSB 35
`define CVSM_FIELD_W 5
`define CVSM_FIELD_NUM 7
`define CVSM_CNT_W 3

// channel counts
`define CVSM_VT_NUM 13
`define CVSM_SG_NUM 8

`endif

// >>> hdl/cvsm_toggle_ram.v
// toggle position storage for the vertical transfer channels
`timescale 1ns/100ps
`include "cvsm_defs.vh"

module cvsm_toggle_ram (
    input wire pclk,
    input wire wr_en,
    input wire [`CVSM_TOG_AW-1:0] wr_addr,
    input wire [`CVSM_TOG_WORD_W-1:0] wr_data,
    input wire [`CVSM_TOG_AW-1:0] rd_addr,
    output wire [`CVSM_TOG_WORD_W-1:0] rd_data
);

    // two packed positions per word; no reset, contents unknown until written
    reg [`CVSM_TOG_WORD_W-1:0] mem [0:`CVSM_TOG_DEPTH-1];

    ////////////////////////////////////////////////////////////////////////////
    // write port, one word per accepted bus write
    always @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // asynchronous read; the bus slave registers it
    assign rd_data = mem[rd_addr];

endmodule

// >>> hdl/cvsm_top.v
// apb register bank for vertical standby levels, field-sequence mode and toggle table
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "cvsm_defs.vh"

module cvsm_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`CVSM_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire vertical_sync,
    input wire standby1_in,
    input wire standby2_in,
    input wire output_gate_input,
    input wire [`CVSM_VT_NUM-1:0] vt_pattern_in,
    input wire [`CVSM_SG_NUM-1:0] sg_pattern_in,
    input wire sub_pattern_in,
    output reg [`CVSM_VT_NUM-1:0] vertical_transfer_output,
    output reg [`CVSM_SG_NUM-1:0] sensor_gate_output,
    output reg substrate_clock_output,
    output reg [`CVSM_FIELD_W-1:0] field_select,
    output reg [`CVSM_CNT_W-1:0] field_index
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    reg [`CVSM_POL_W-1:0] pol_r; // standby idle polarity register
    reg [`CVSM_MODE_W-1:0] mode_pend_r; // mode as written, waiting for sync
    reg [`CVSM_MODE_W-1:0] mode_act_r; // mode in effect
    reg [2:0] vs_sync_r; // vertical sync synchroniser plus edge stage
    reg [1:0] sb1_sync_r; // standby 1 synchroniser
    reg [1:0] sb2_sync_r; // standby 2 synchroniser
    reg [1:0] og_sync_r; // output gate synchroniser
    reg [`CVSM_CNT_W-1:0] fidx_nxt; // next field index
    reg [31:0] rdata_nxt; // read data for the coming access
    reg rerr_nxt; // unmapped address or read-only write flag
    wire [`CVSM_IDX_W-1:0] idx; // word index of the bus address
    wire mode_hit; // address selects the mode register
    wire tog_hit; // address selects the toggle table
    wire setup_ph; // setup phase of a transfer
    wire wr_acc; // write taking effect this edge
    wire vs_rise; // synchronised vertical sync rising edge
    wire idle_lvl; // outputs forced to polarity levels
    wire [`CVSM_MODE_W-1:0] mode_src; // mode whose fields feed the selection
    wire [`CVSM_TOG_WORD_W-1:0] tog_rd; // toggle table read word
    wire [`CVSM_FIELD_W-1:0] fsel_mux [0:`CVSM_FIELD_NUM-1]; // field selections

    assign idx = paddr[`CVSM_IDX_MSB:`CVSM_IDX_LSB];
    // mode register is any index whose top two bits are 10
    assign mode_hit = (idx[`CVSM_MODE_SEL_MSB:`CVSM_MODE_SEL_LSB] == `CVSM_MODE_SEL_CODE);
    assign tog_hit = (idx[`CVSM_IDX_W-1:`CVSM_TOG_AW] == `CVSM_TOG_HI_IDX);
    assign setup_ph = psel & ~penable;
    // pready is only high in the access cycle, so this fires once per transfer
    assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
    assign vs_rise = vs_sync_r[1] & ~vs_sync_r[2];
    assign idle_lvl = sb1_sync_r[1] | sb2_sync_r[1] | ~og_sync_r[1];
    // at the update edge the selection follows the mode being loaded, never the old one
    assign mode_src = vs_rise ? mode_pend_r : mode_act_r;

    ////////////////////////////////////////////////////////////////////////////
    // field selection slices, field 1 in the lowest five bits
    genvar gi;
    generate
        for (gi = 0; gi < `CVSM_FIELD_NUM; gi = gi + 1) begin : g_fsel
            assign fsel_mux[gi] = mode_src[gi*`CVSM_FIELD_W +: `CVSM_FIELD_W];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // toggle position table
    cvsm_toggle_ram u_tog (
        .pclk(pclk),
        .wr_en(wr_acc & tog_hit),
        .wr_addr(idx[`CVSM_TOG_AW-1:0]),
        .wr_data(pwdata[`CVSM_TOG_WORD_W-1:0]),
        .rd_addr(idx[`CVSM_TOG_AW-1:0]),
        .rd_data(tog_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers; the second stage is looked at, plus the third for the sync edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vs_sync_r <= 3'h0;
            sb1_sync_r <= 2'h0;
            sb2_sync_r <= 2'h0;
            og_sync_r <= 2'h0;
        end else begin
            vs_sync_r <= {vs_sync_r[1:0], vertical_sync};
            sb1_sync_r <= {sb1_sync_r[0], standby1_in};
            sb2_sync_r <= {sb2_sync_r[0], standby2_in};
            og_sync_r <= {og_sync_r[0], output_gate_input};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data and error decode for the coming access phase
    always @* begin
        rdata_nxt = 32'h00000000;
        rerr_nxt = 1'b0;
        if (mode_hit) begin
            // pending low bits; high bits are readable separately
            rdata_nxt[`CVSM_MODE_LOW_W-1:0] = mode_pend_r[`CVSM_MODE_LOW_W-1:0];
        end else if (tog_hit) begin
            rdata_nxt[`CVSM_TOG_WORD_W-1:0] = tog_rd;
        end else begin
            case (idx)
                `CVSM_IDX_POL: begin
                    rdata_nxt[`CVSM_POL_W-1:0] = pol_r;
                end
                `CVSM_IDX_MODE_ACT_LO: begin
                    rdata_nxt[`CVSM_MODE_LOW_W-1:0] = mode_act_r[`CVSM_MODE_LOW_W-1:0];
                end
                `CVSM_IDX_MODE_ACT_HI: begin
                    rdata_nxt[`CVSM_MODE_ADDR_DATA_W-1:0] = mode_act_r[`CVSM_MODE_W-1:`CVSM_MODE_LOW_W];
                end
                `CVSM_IDX_FIELD_STAT: begin
                    rdata_nxt[`CVSM_FIELD_W-1:0] = field_select;
                    rdata_nxt[`CVSM_FIELD_W+`CVSM_CNT_W-1:`CVSM_FIELD_W] = field_index;
                end
                `CVSM_IDX_MODE_PEND_HI: begin
                    rdata_nxt[`CVSM_MODE_ADDR_DATA_W-1:0] = mode_pend_r[`CVSM_MODE_W-1:`CVSM_MODE_LOW_W];
                end
                default: begin
                    // unmapped address answers with an error
                    rerr_nxt = 1'b1;
                end
            endcase
        end
        // status words are read only
        if (pwrite && (idx == `CVSM_IDX_MODE_ACT_LO || idx == `CVSM_IDX_MODE_ACT_HI ||
            idx == `CVSM_IDX_FIELD_STAT || idx == `CVSM_IDX_MODE_PEND_HI)) begin
            rerr_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: ready in the first access cycle, no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & rerr_nxt;
            if (setup_ph && !pwrite) begin
                prdata <= rdata_nxt;
            end else if (!psel) begin
                prdata <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // polarity register write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_r <= `CVSM_POL_RESET;
        end else if (wr_acc && !mode_hit && idx == `CVSM_IDX_POL) begin
            pol_r <= pwdata[`CVSM_POL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode register: address carries D37:D28, data bus carries D27:D0
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_pend_r <= `CVSM_MODE_RESET;
        end else if (wr_acc && mode_hit) begin
            mode_pend_r <= {idx[`CVSM_MODE_ADDR_DATA_W-1:0], pwdata[`CVSM_MODE_LOW_W-1:0]};
        end
    end

    // pending mode becomes active only on the vertical sync edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_act_r <= `CVSM_MODE_RESET;
        end else if (vs_rise) begin
            mode_act_r <= mode_pend_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field sequencer: steps through the selected fields once per sync
    always @* begin
        fidx_nxt = field_index;
        if (vs_rise) begin
            // count taken from the mode being loaded; zero or one holds field 1
            if (mode_pend_r[`CVSM_MODE_CNT_MSB:`CVSM_MODE_CNT_LSB] <= 3'h1) begin
                fidx_nxt = 3'h0;
            end else if (field_index >= mode_pend_r[`CVSM_MODE_CNT_MSB:`CVSM_MODE_CNT_LSB] - 3'h1) begin
                fidx_nxt = 3'h0;
            end else begin
                fidx_nxt = field_index + 3'h1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            field_index <= 3'h0;
            field_select <= 5'h00;
        end else begin
            field_index <= fidx_nxt;
            // index never exceeds six because the count is at most seven
            field_select <= (fidx_nxt == 3'h7) ? fsel_mux[0] : fsel_mux[fidx_nxt];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output stage: polarity levels while idle, live pattern otherwise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vertical_transfer_output <= 13'h0000;
            sensor_gate_output <= 8'h00;
            substrate_clock_output <= 1'b0;
        end else if (idle_lvl) begin
            vertical_transfer_output <= pol_r[`CVSM_POL_VT_MSB:`CVSM_POL_VT_LSB];
            sensor_gate_output <= pol_r[`CVSM_POL_SG_MSB:`CVSM_POL_SG_LSB];
            substrate_clock_output <= pol_r[`CVSM_POL_SUB_BIT];
        end else begin
            vertical_transfer_output <= vt_pattern_in;
            sensor_gate_output <= sg_pattern_in;
            substrate_clock_output <= sub_pattern_in;
        end
    end

endmodule

// >>> testbench/cvsm_top_assertions.sv
// concurrent checks on the cvsm_top ports
`timescale 1ns/100ps
`include "cvsm_defs.vh"
module cvsm_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`CVSM_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire vertical_sync,
    input wire standby1_in,
    input wire standby2_in,
    input wire output_gate_input,
    input wire [`CVSM_VT_NUM-1:0] vt_pattern_in,
    input wire [`CVSM_SG_NUM-1:0] sg_pattern_in,
    input wire sub_pattern_in,
    input wire [`CVSM_VT_NUM-1:0] vertical_transfer_output,
    input wire [`CVSM_SG_NUM-1:0] sensor_gate_output,
    input wire substrate_clock_output,
    input wire [`CVSM_CNT_W-1:0] field_index
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [`CVSM_POL_W-1:0] pol_r; // polarity as last written on the bus
    reg [2:0] live_r; // cycles since reset, saturating at seven
    wire idle_w = standby1_in | standby2_in | ~output_gate_input;
    wire live_w = live_r == 3'h7;
    ////////////////////////////////////////////////////////////////
    // shadow of the polarity word; skip the sync settling after reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_r <= 22'h000000;
            live_r <= 3'h0;
        end else begin
            if (!live_w) begin
                live_r <= live_r + 3'h1;
            end
            if (psel && penable && pready && pwrite && paddr[13:2] == `CVSM_IDX_POL) begin
                pol_r <= pwdata[21:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence idle_held_s;
        (idle_w && live_w && $stable(pol_r)) [*5];
    endsequence
    sequence run_held_s;
        (!idle_w && live_w) [*5];
    endsequence
    vt_idle_level_a: assert property (idle_held_s |-> vertical_transfer_output == pol_r[12:0])
        else $error("vertical idle level wrong");
    sg_idle_level_a: assert property (idle_held_s |-> sensor_gate_output == pol_r[20:13])
        else $error("sensor gate idle level wrong");
    sub_idle_level_a: assert property (idle_held_s |-> substrate_clock_output == pol_r[21])
        else $error("substrate idle level wrong");
    vt_run_path_a: assert property (run_held_s |-> vertical_transfer_output == $past(vt_pattern_in))
        else $error("vertical output not following pattern");
    sg_run_path_a: assert property (run_held_s |-> sensor_gate_output == $past(sg_pattern_in))
        else $error("sensor gate output not following pattern");
    sub_run_path_a: assert property (run_held_s |-> substrate_clock_output == $past(sub_pattern_in))
        else $error("substrate output not following pattern");
    field_at_sync_a: assert property ($changed(field_index) |-> $past(vertical_sync, 3) && !$past(vertical_sync, 6))
        else $error("field index moved without sync edge");
    field_count_max_a: assert property (field_index != 3'h7)
        else $error("field index beyond seven fields");
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ro_write_err_a: assert property (psel && !penable && pwrite && paddr[13:2] == `CVSM_IDX_MODE_ACT_LO |=> pslverr)
        else $error("write to read-only word not refused");
endmodule
bind cvsm_top cvsm_chk chk (.*);

// >>> testbench/cvsm_host.sv
// apb host model programming the configuration registers
`timescale 1ns/100ps
`include "cvsm_defs.vh"
module cvsm_host (
    input wire pclk,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    output reg psel = 1'h0,
    output reg penable = 1'h0,
    output reg pwrite = 1'h0,
    output reg [`CVSM_ADDR_W-1:0] paddr = 14'h0000,
    output reg [31:0] pwdata = 32'h00000000
);
    int stalls = 0; // transfers that needed a wait state
    ////////////////////////////////////////////////////////////////
    // one transfer: setup, access held until pready, then release
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // wait as long as it takes; only the bench watchdog ends a hang
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1);
        if (n > 1) stalls++;
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // mode word: top ten data bits ride on the address
    task mode_wr(input logic [37:0] m);
        logic [31:0] q;
        logic e;
        apb(1'h1, {2'h2, m[37:28], 2'h0}, {4'h0, m[27:0]}, q, e);
    endtask
    // unused channel toggles set to maximum before use
    task fill_unused();
        logic [31:0] q;
        logic e;
        for (int i = 16; i < 32; i++) apb(1'h1, {i[11:0], 2'h0}, 32'hFFFFFFFF, q, e);
    endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench for cvsm_top
`timescale 1ns/100ps
`include "cvsm_defs.vh"
module tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [`CVSM_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [31:0] pat = 32'h00000000; // pattern word for the next rising edge
    logic vertical_sync = 1'h0, standby1_in = 1'h0, standby2_in = 1'h0, output_gate_input = 1'h1;
    logic [`CVSM_VT_NUM-1:0] vt_pattern_in = 13'h0000, vertical_transfer_output;
    logic [`CVSM_SG_NUM-1:0] sg_pattern_in = 8'h00, sensor_gate_output;
    logic sub_pattern_in = 1'h0, substrate_clock_output;
    logic [`CVSM_FIELD_W-1:0] field_select;
    logic [`CVSM_CNT_W-1:0] field_index;
    logic [31:0] rs = 32'h0000001D; // xorshift state
    logic [37:0] m, am; // mode written, mode active
    logic [21:0] p; // polarity written
    logic [2:0] idx; // expected field index
    int fail_count = 0, check_count = 0;
    cvsm_top dut (.*);
    cvsm_host host (.*);
    always #12.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // next field index: counts of zero or one hold field 0
    function automatic logic [2:0] nxt(input logic [2:0] i, input logic [2:0] c);
        return (c <= 3'h1) ? 3'h0 : (i + 3'h1) % c;
    endfunction
    task chk(input string nm, input logic [37:0] s, input logic [37:0] x);
        check_count++;
        if (s !== x) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task rd(input logic [11:0] i, input logic [37:0] x, input string nm);
        host.apb(1'h0, {i, 2'h0}, 32'h0, q, e);
        chk(nm, q, x);
    endtask
    task rst();
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        idx = 3'h0;
        am = 38'h0;
    endtask
    task results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // random live patterns every cycle; drawn on the falling edge so that the
    // main thread never advances the generator in the same time step
    always @(negedge pclk) begin
        pat = rnd();
    end
    always @(posedge pclk) begin
        {vt_pattern_in, sg_pattern_in, sub_pattern_in} <= pat[21:0];
    end
    // watchdog against a hung handshake
    initial begin
        #(25 * 40000);
        fail_count++;
        results();
    end
    initial begin
        rst();
        rd(`CVSM_IDX_POL, 38'h0, "pol reset");
        rd(`CVSM_IDX_MODE_ACT_HI, 38'h0, "mode reset");
        $display("test 1 done");
        q = rnd();
        p = q[21:0];
        host.apb(1'h1, {`CVSM_IDX_POL, 2'h0}, {10'h000, p}, q, e);
        rd(`CVSM_IDX_POL, p, "pol readback");
        // each gating cause in turn
        for (int c = 0; c < 3; c++) begin
            @(posedge pclk);
            standby1_in <= (c == 0);
            standby2_in <= (c == 1);
            output_gate_input <= (c != 2);
            repeat (6) @(posedge pclk);
            #1;
            chk("vt idle", vertical_transfer_output, p[12:0]);
            chk("sg idle", sensor_gate_output, p[20:13]);
            chk("sub idle", substrate_clock_output, p[21]);
        end
        @(posedge pclk);
        standby1_in <= 1'h0;
        standby2_in <= 1'h0;
        output_gate_input <= 1'h1;
        $display("test 2 done");
        host.apb(1'h1, {`CVSM_IDX_MODE_ACT_LO, 2'h0}, 32'h1, q, e);
        chk("ro err", e, 1'h1);
        rd(12'h100, 38'h0, "unmapped");
        chk("unmapped err", e, 1'h1);
        $display("test 3 done");
        // field counts seven, one and three
        for (int k = 0; k < 3; k++) begin
            q = rnd();
            m = {(k == 0) ? 3'h7 : (k == 1) ? 3'h1 : 3'h3, q[2:0], rnd()};
            host.mode_wr(m);
            rd({2'h2, m[37:28]}, m[27:0], "mode low");
            rd(`CVSM_IDX_MODE_PEND_HI, m[37:28], "pending high");
            rd(`CVSM_IDX_MODE_ACT_HI, am[37:28], "before sync");
            vertical_sync <= 1'h1;
            repeat (6) @(posedge pclk);
            vertical_sync <= 1'h0;
            repeat (6) @(posedge pclk);
            idx = nxt(idx, m[37:35]);
            am = m;
            rd(`CVSM_IDX_MODE_ACT_LO, m[27:0], "active low");
            rd(`CVSM_IDX_MODE_ACT_HI, m[37:28], "active high");
            chk("field index", field_index, idx);
            chk("field select", field_select, m[5 * idx +: 5]);
        end
        $display("test 4 done");
        host.fill_unused();
        rd(12'h010, 38'h3FFFFFF, "toggle first");
        rd(12'h01F, 38'h3FFFFFF, "toggle last");
        $display("test 5 done");
        rst();
        rd(`CVSM_IDX_POL, 38'h0, "pol rereset");
        rd(`CVSM_IDX_MODE_PEND_HI, 38'h0, "mode rereset");
        chk("bus stalls", host.stalls, 38'h0);
        $display("test 6 done");
        results();
    end
endmodule
